/* hdl/serial_comm_defs.vh */
// constants for the asynchronous serial communication interface
`ifndef SERIAL_COMM_DEFS_VH
`define SERIAL_COMM_DEFS_VH
// register byte addresses
`define OFS_STATUS      8'h00
`define OFS_DATA        8'h04
`define OFS_BAUD        8'h08
`define OFS_CTRL1       8'h0c
`define OFS_CTRL2       8'h10
`define OFS_RX_EXT      8'h14
`define OFS_TX_EXT      8'h18
// reset values
`define RST_BAUD        8'h00
`define RST_BYTE        8'h00
// control one fields
`define C1_WORD9        4
`define C1_WAKE_ADDR    3
`define C1_TX_BIT8      6
// control two fields
`define C2_TX_EN        3
`define C2_RX_EN        2
`define C2_MUTE         1
`define C2_BREAK        0
// baud fields
`define BR_PRE_HI       7
`define BR_PRE_LO       6
`define BR_TX_HI        5
`define BR_TX_LO        3
`define BR_RX_HI        2
`define BR_RX_LO        0
// status fields
`define ST_TX_EMPTY     7
`define ST_TX_DONE      6
`define ST_RX_FULL      5
`define ST_IDLE         4
`define ST_OVERRUN      3
`define ST_NOISE        2
`define ST_FRAME        1
`define ST_RX_BIT8      0
// oversampling figures
`define OVS_LAST        4'hf
`define OVS_VOTE_A      4'h7
`define OVS_VOTE_B      4'h8
`define OVS_VOTE_C      4'h9
// start and stop bits around the data bits of a frame
`define FRM_OVERHEAD    4'h2
`endif

/* hdl/serial_comm.v */
// asynchronous serial interface with apb register file
`timescale 1ns/1ps
`include "serial_comm_defs.vh"
module serial_comm #(
  parameter PRE_W = 8  // unused; extended prescalers are fixed at 8 bits
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_pin,
  output reg         tx_pin
);
  // registers
  reg [7:0]  baud_rate_divider_q;          // prescaler and divider selects
  reg [7:0]  control_reg_one_q;            // word length, wake mode, ninth tx bit
  reg [7:0]  control_reg_two_q;            // enables, mute, break
  reg [7:0]  rx_extended_prescaler_reg_q;  // extra rx division
  reg [7:0]  tx_extended_prescaler_reg_q;  // extra tx division
  reg [8:0]  tx_data_buffer_q;             // word waiting to transmit
  reg [8:0]  rx_data_buffer_q;             // last received word
  reg        tx_empty_q;                   // tx buffer empty
  reg        tx_done_q;                    // shifter idle
  reg        rx_data_full_flag_q;          // received word waiting
  reg        idle_q;                       // idle line seen
  reg        overrun_q;                    // word lost
  reg        noise_flag_q;                 // vote disagreement
  reg        frame_err_q;                  // bad stop bit
  reg        break_pend_q;                 // one break owed after clear
  // bus decode, single-cycle answer
  wire       acc   = psel & penable & pready;
  wire       wr    = acc & pwrite;
  wire       rd    = acc & ~pwrite;
  wire       word9 = control_reg_one_q[`C1_WORD9];
  // status byte
  wire [7:0] status = {tx_empty_q, tx_done_q, rx_data_full_flag_q, idle_q,
                       overrun_q, noise_flag_q, frame_err_q, rx_data_buffer_q[8]};

  // total divisor: first prescaler times 2^select times extended prescaler
  function [23:0] divisor;
    input [1:0] pre;
    input [2:0] sel;
    input [7:0] ext;
    reg   [7:0] p;
    begin
      case (pre)
        2'h0:    p = 8'h01;
        2'h1:    p = 8'h03;
        2'h2:    p = 8'h04;
        default: p = 8'h0d;
      endcase
      divisor = ({16'h0000, p} << sel) * {16'h0000, (ext == 8'h00) ? 8'h01 : ext};
    end
  endfunction

  // two independent generators of 16x tick enables
  reg  [23:0] tx_div_q;
  reg  [23:0] rx_div_q;
  reg         tx_tick_q;
  reg         rx_tick_q;
  wire [23:0] tx_lim = divisor(baud_rate_divider_q[`BR_PRE_HI:`BR_PRE_LO],
                               baud_rate_divider_q[`BR_TX_HI:`BR_TX_LO],
                               tx_extended_prescaler_reg_q);
  wire [23:0] rx_lim = divisor(baud_rate_divider_q[`BR_PRE_HI:`BR_PRE_LO],
                               baud_rate_divider_q[`BR_RX_HI:`BR_RX_LO],
                               rx_extended_prescaler_reg_q);
  // dividers free-run; a one-cycle pulse marks each sample instant
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_div_q  <= 24'h000000;
      rx_div_q  <= 24'h000000;
      tx_tick_q <= 1'b0;
      rx_tick_q <= 1'b0;
    end else begin
      tx_tick_q <= (tx_div_q + 24'h000001 >= tx_lim);
      rx_tick_q <= (rx_div_q + 24'h000001 >= rx_lim);
      tx_div_q  <= (tx_div_q + 24'h000001 >= tx_lim) ? 24'h000000 : tx_div_q + 24'h000001;
      rx_div_q  <= (rx_div_q + 24'h000001 >= rx_lim) ? 24'h000000 : rx_div_q + 24'h000001;
    end
  end

  // receive pin synchroniser; only stage two is read
  reg rx_s1_q;
  reg rx_s2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // transmitter state machine
  localparam [3:0] TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_STOP = 4'b1000;
  reg [3:0] tx_st_q;
  reg [3:0] tx_ph_q;    // sixteenth of bit
  reg [3:0] tx_bit_q;   // data bit index
  reg [8:0] tx_sh_q;    // output shift register
  reg       tx_brk_q;   // current frame is a break
  reg       tx_load;    // shifter takes buffer this cycle
  wire      tx_en  = control_reg_two_q[`C2_TX_EN];
  wire      brk_on = control_reg_two_q[`C2_BREAK];
  wire [3:0] nbits = word9 ? 4'h9 : 4'h8;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q  <= TX_IDLE;
      tx_ph_q  <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 9'h1ff;
      tx_brk_q <= 1'b0;
      tx_pin   <= 1'b1;
      tx_load  <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      if (tx_tick_q) begin
        case (tx_st_q)
          TX_IDLE: begin
            tx_pin <= 1'b1;
            if (tx_en && (brk_on || break_pend_q)) begin
              tx_brk_q <= 1'b1;
              tx_st_q  <= TX_START;
              tx_ph_q  <= 4'h0;
            end else if (tx_en && !tx_empty_q) begin
              tx_sh_q  <= tx_data_buffer_q;
              tx_load  <= 1'b1;
              tx_brk_q <= 1'b0;
              tx_st_q  <= TX_START;
              tx_ph_q  <= 4'h0;
            end
          end
          TX_START: begin
            tx_pin <= 1'b0;
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `OVS_LAST) begin
              tx_st_q  <= TX_DATA;
              tx_bit_q <= 4'h0;
            end
          end
          TX_DATA: begin
            tx_pin <= tx_brk_q ? 1'b0 : tx_sh_q[0];
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `OVS_LAST) begin
              tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q + 4'h1 == nbits)
                tx_st_q <= TX_STOP;
            end
          end
          TX_STOP: begin
            // a break keeps stop low; next break frame or the closing high bit follows
            tx_pin <= tx_brk_q ? 1'b0 : 1'b1;
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `OVS_LAST) begin
              if (tx_brk_q && brk_on)
                tx_st_q <= TX_START;
              else if (tx_brk_q)
                tx_brk_q <= 1'b0;  // one more stop pass, now high: full closing bit
              else
                tx_st_q <= TX_IDLE;
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  // receiver state machine
  localparam [3:0] RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000;
  reg [3:0] rx_st_q;
  reg [3:0] rx_ph_q;
  reg [3:0] rx_bit_q;
  reg [8:0] rx_sh_q;      // input shift register
  reg [2:0] rx_hist_q;    // last three idle samples
  reg [2:0] vote_q;       // samples at phases 7 and 8; the phase 9 sample is read live
  reg [7:0] idle_run_q;   // high samples since the line last went low
  reg       idle_arm_q;   // a frame ended; idle may be reported once
  reg       rx_noise_q;   // noise seen in frame
  reg       rx_ev;        // word completed this cycle
  reg       rx_idle_ev;   // idle character this cycle
  reg       wake_ev;      // wake-up recognised this cycle
  reg       rx_frm;       // stop bit read low
  wire      muted  = control_reg_two_q[`C2_MUTE];
  wire      wake_a = control_reg_one_q[`C1_WAKE_ADDR];
  wire      maj    = (vote_q[0] & vote_q[1]) | (vote_q[1] & rx_s2_q) | (vote_q[0] & rx_s2_q);
  wire      disag  = ~((vote_q[0] == vote_q[1]) & (vote_q[1] == rx_s2_q));
  wire [7:0] idle_lim = {nbits + `FRM_OVERHEAD, 4'h0};  // samples in one whole frame
  // third vote sample is the live one at phase nine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q    <= RX_IDLE;
      rx_ph_q    <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 9'h000;
      rx_hist_q  <= 3'h0;
      vote_q     <= 3'h0;
      idle_run_q <= 8'h00;
      idle_arm_q <= 1'b0;
      rx_noise_q <= 1'b0;
      rx_ev      <= 1'b0;
      rx_idle_ev <= 1'b0;
      wake_ev    <= 1'b0;
      rx_frm     <= 1'b0;
    end else begin
      rx_ev      <= 1'b0;
      rx_idle_ev <= 1'b0;
      wake_ev    <= 1'b0;
      // one sample per tick; a late edge shifts by at most a tick
      if (rx_tick_q && control_reg_two_q[`C2_RX_EN]) begin
        case (rx_st_q)
          RX_IDLE: begin
            rx_hist_q <= {rx_hist_q[1:0], rx_s2_q};
            if (!rx_s2_q) begin
              rx_st_q    <= RX_START;
              rx_ph_q    <= 4'h1;  // phase restarts at start edge
              rx_noise_q <= (rx_hist_q != 3'h7);
              idle_run_q <= 8'h00;
            end else if (idle_run_q + 8'h01 == idle_lim) begin
              // a frame time of high line; a data word of all ones is still stored
              idle_run_q <= 8'h00;
              idle_arm_q <= 1'b0;
              rx_idle_ev <= idle_arm_q;
              if (idle_arm_q && muted && !wake_a) wake_ev <= 1'b1;
            end else begin
              idle_run_q <= idle_run_q + 8'h01;
            end
          end
          default: begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `OVS_VOTE_A) vote_q[0] <= rx_s2_q;
            if (rx_ph_q == `OVS_VOTE_B) vote_q[1] <= rx_s2_q;
            if (rx_ph_q == `OVS_VOTE_C) begin
              if (disag) rx_noise_q <= 1'b1;
              case (rx_st_q)
                RX_START: begin
                  if (maj) begin
                    rx_st_q <= RX_IDLE;  // false start
                    rx_hist_q <= 3'h0;
                  end else begin
                    rx_st_q  <= RX_DATA;
                    rx_bit_q <= 4'h0;
                  end
                end
                RX_DATA: begin
                  rx_sh_q   <= word9 ? {maj, rx_sh_q[8:1]} : {1'b0, maj, rx_sh_q[7:1]};
                  rx_bit_q  <= rx_bit_q + 4'h1;
                  if (rx_bit_q + 4'h1 == nbits) rx_st_q <= RX_STOP;
                end
                default: begin
                  // stop sampled: frame ends here
                  rx_st_q   <= RX_IDLE;
                  rx_hist_q <= 3'h0;
                  rx_frm     <= ~maj;
                  idle_run_q <= 8'h00;
                  idle_arm_q <= 1'b1;  // no idle report before a real frame
                  if (muted && wake_a &&
                               (word9 ? rx_sh_q[8] : rx_sh_q[7])) begin
                    wake_ev <= 1'b1;  // address mark wakes
                    rx_ev   <= 1'b1;
                  end else if (!muted) begin
                    rx_ev <= 1'b1;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // register file, status flags and bus answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_rate_divider_q         <= `RST_BAUD;
      control_reg_one_q           <= `RST_BYTE;
      control_reg_two_q           <= `RST_BYTE;
      rx_extended_prescaler_reg_q <= `RST_BYTE;
      tx_extended_prescaler_reg_q <= `RST_BYTE;
      tx_data_buffer_q            <= 9'h000;
      rx_data_buffer_q            <= 9'h000;
      tx_empty_q                  <= 1'b1;
      tx_done_q                   <= 1'b1;
      rx_data_full_flag_q         <= 1'b0;
      idle_q                      <= 1'b0;
      overrun_q                   <= 1'b0;
      noise_flag_q                <= 1'b0;
      frame_err_q                 <= 1'b0;
      break_pend_q                <= 1'b0;
      prdata                      <= 32'h00000000;
      pready                      <= 1'b0;
      pslverr                     <= 1'b0;
    end else begin
      // answer in the access cycle's second edge
      pready  <= psel & ~pready & penable;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
        pslverr <= ~(paddr == `OFS_STATUS || paddr == `OFS_DATA || paddr == `OFS_BAUD ||
                     paddr == `OFS_CTRL1 || paddr == `OFS_CTRL2 || paddr == `OFS_RX_EXT ||
                     paddr == `OFS_TX_EXT);
      // reads
      if (psel & penable & ~pready) begin
        case (paddr)
          `OFS_STATUS: prdata <= {24'h000000, status};
          `OFS_DATA:   prdata <= {24'h000000, rx_data_buffer_q[7:0]};
          `OFS_BAUD:   prdata <= {24'h000000, baud_rate_divider_q};
          `OFS_CTRL1:  prdata <= {24'h000000, control_reg_one_q};
          `OFS_CTRL2:  prdata <= {24'h000000, control_reg_two_q};
          `OFS_RX_EXT: prdata <= {24'h000000, rx_extended_prescaler_reg_q};
          `OFS_TX_EXT: prdata <= {24'h000000, tx_extended_prescaler_reg_q};
          default:     prdata <= 32'h00000000;
        endcase
      end
      // data read empties rx buffer; clears of error flags too
      if (rd && paddr == `OFS_DATA) begin
        rx_data_full_flag_q <= 1'b0;
        overrun_q           <= 1'b0;
        noise_flag_q        <= 1'b0;
        frame_err_q         <= 1'b0;
        idle_q              <= 1'b0;
      end
      // writes
      if (wr) begin
        case (paddr)
          `OFS_DATA: begin
            tx_data_buffer_q <= {control_reg_one_q[`C1_TX_BIT8], pwdata[7:0]};
            tx_empty_q       <= 1'b0;
            tx_done_q        <= 1'b0;
          end
          `OFS_BAUD:   baud_rate_divider_q <= pwdata[7:0];
          `OFS_CTRL1:  control_reg_one_q <= pwdata[7:0];
          `OFS_RX_EXT: rx_extended_prescaler_reg_q <= pwdata[7:0];
          `OFS_TX_EXT: tx_extended_prescaler_reg_q <= pwdata[7:0];
          `OFS_CTRL2: begin
            control_reg_two_q[7:2] <= pwdata[7:2];
            control_reg_two_q[`C2_BREAK] <= pwdata[`C2_BREAK];
            // falling break bit owes one break word
            if (brk_on && !pwdata[`C2_BREAK]) break_pend_q <= 1'b1;
            if (!(wake_a && rx_data_full_flag_q))
              control_reg_two_q[`C2_MUTE] <= pwdata[`C2_MUTE];
          end
          default: ;
        endcase
      end
      // hardware events win over software clears
      if (tx_load) tx_empty_q <= 1'b1;
      if (tx_st_q == TX_START && tx_brk_q) break_pend_q <= 1'b0;
      if (tx_tick_q && tx_st_q == TX_IDLE && tx_empty_q && !brk_on && !break_pend_q)
        tx_done_q <= 1'b1;
      if (wake_ev) control_reg_two_q[`C2_MUTE] <= 1'b0;
      if (rx_idle_ev && !muted) idle_q <= 1'b1;
      if (rx_ev) begin
        if (rx_data_full_flag_q) begin
          overrun_q <= 1'b1;
        end else begin
          rx_data_buffer_q    <= rx_sh_q;
          rx_data_full_flag_q <= 1'b1;
          noise_flag_q        <= rx_noise_q;
          frame_err_q         <= rx_frm;
        end
      end
    end
  end
endmodule // serial_comm

/* verification/serial_comm_props.sv */
// concurrent checks on the ports of the serial interface
`timescale 1ns/1ps
module serial_comm_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_pin
);
  reg       prev_q;  // tx level one cycle ago
  reg [7:0] run_q;   // cycles the tx level has held
  wire      hole;    // address outside the seven words
  assign hole = (paddr > 8'h18) || (paddr[1:0] != 2'b00);
  // run length of the tx line; saturates so a long idle never wraps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b1;
      run_q  <= 8'hff;
    end else begin
      prev_q <= tx_pin;
      run_q  <= (tx_pin != prev_q) ? 8'h00 : (run_q == 8'hff) ? run_q : run_q + 8'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_access; pready |-> psel && penable; endproperty
  a_access: assert property (p_access) else $error("ready outside access");
  property p_map; pready |-> pslverr == hole; endproperty
  a_map: assert property (p_map) else $error("error flag vs map");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error with data");
  property p_high_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper data set");
  property p_bit_len; tx_pin != prev_q |-> run_q >= 8'h0f; endproperty
  a_bit_len: assert property (p_bit_len) else $error("short tx bit");
  property p_idle; $rose(presetn) |-> tx_pin && !pready; endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
endmodule // serial_comm_props

/* verification/serial_node.sv */
// remote serial node: drives the rx line and decodes the tx line
`timescale 1ns/1ps
module serial_node #(
  parameter TX_CYC = 16,  // pclk per bit seen on tx
  parameter RX_CYC = 32   // pclk per bit sent to rx
) (
  input wire pclk,
  input wire tx_line,
  output reg rx_line
);
  reg [8:0] got_q;   // last word decoded
  reg       stop_q;  // its stop level
  integer   got_n;   // words decoded
  integer   width;   // data bits expected
  initial begin
    rx_line = 1'b1;
    got_n = 0;
    width = 8;
  end
  // one frame lsb first; bit bad gets a one-tick glitch on its middle vote
  task send(input [8:0] w, input integer n, input integer bad);
    integer i;
    begin
      rx_line <= 1'b0;  // start bit low
      repeat (RX_CYC) @(posedge pclk);
      for (i = 0; i < n; i = i + 1) begin
        rx_line <= w[i];  // lsb first
        repeat (16) @(posedge pclk);
        if (i == bad) rx_line <= ~w[i];
        repeat (2) @(posedge pclk);
        rx_line <= w[i];
        repeat (RX_CYC - 18) @(posedge pclk);
      end
      rx_line <= 1'b1;  // stop bit, then idle high
      repeat (RX_CYC) @(posedge pclk);
    end
  endtask
  // decode at bit centres; a break shows as zero data and a low stop
  always begin : decode
    integer k;
    @(negedge tx_line);
    repeat (TX_CYC / 2) @(posedge pclk);
    got_q = 9'h000;
    for (k = 0; k < width; k = k + 1) begin
      repeat (TX_CYC) @(posedge pclk);
      got_q[k] = tx_line;
    end
    repeat (TX_CYC) @(posedge pclk);
    stop_q = tx_line;
    got_n = got_n + 1;
  end
endmodule // serial_node

/* verification/serial_comm_tb.sv */
// self-checking bench for the serial interface
`timescale 1ns/1ps
`include "serial_comm_defs.vh"
module serial_comm_tb;
  reg         pclk, presetn, psel, penable, pwrite;  // apb master side
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, rx_pin, tx_pin;
  reg  [31:0] rd_q;  // data of last access
  reg         err_q;  // error of last access
  integer     fail_count, total_checks, k;
  serial_comm uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin));
  serial_node #(.TX_CYC(16), .RX_CYC(32)) node (.pclk(pclk), .tx_line(tx_pin), .rx_line(rx_pin));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer; pready is read before this edge's updates land
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("BAD %0t: no bus answer", $time);
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd_q, exp);
    end
  endtask
  task wait_frame(input [8:0] w, input s);
    integer n0, n;
    begin
      n0 = node.got_n;
      n = 0;
      while (node.got_n == n0 && n < 3000) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (node.got_n == n0) begin
        fail_count = fail_count + 1;
        $display("BAD %0t: no frame seen", $time);
      end
      check(node.got_q, w);
      check(node.stop_q, s);
    end
  endtask
  task t_regs;
    begin
      rd_chk(`OFS_BAUD, 32'h0);
      rd_chk(`OFS_RX_EXT, 32'h0);
      apb(1'b1, `OFS_BAUD, 32'hff);
      rd_chk(`OFS_BAUD, 32'hff);
      apb(1'b1, `OFS_TX_EXT, 32'h3c);
      rd_chk(`OFS_TX_EXT, 32'h3c);
      apb(1'b1, `OFS_TX_EXT, 32'h0);
      rd_chk(8'h1c, 32'h0);
      check(err_q, 1'b1);
      apb(1'b1, `OFS_BAUD, 32'h01);  // rx divides by 2, tx by 1
      apb(1'b1, `OFS_CTRL2, 32'h0c);
    end
  endtask
  task t_tx;
    begin
      apb(1'b1, `OFS_DATA, 32'ha5);
      apb(1'b1, `OFS_DATA, 32'h5c);
      wait_frame(9'h0a5, 1'b1);
      wait_frame(9'h05c, 1'b1);
      apb(1'b1, `OFS_CTRL1, 32'h50);
      node.width = 9;
      apb(1'b1, `OFS_DATA, 32'h3c);
      wait_frame(9'h13c, 1'b1);
      node.width = 8;
      apb(1'b1, `OFS_CTRL1, 32'h0);
    end
  endtask
  task t_rx;
    begin
      node.send(9'h0c3, 8, -1);
      rd_chk(`OFS_STATUS, 32'he0);
      check(rd_q[`ST_RX_FULL], 1'b1);
      rd_chk(`OFS_DATA, 32'hc3);
      node.send(9'h05a, 8, 3);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check(rd_q[`ST_NOISE], 1'b1);
      rd_chk(`OFS_DATA, 32'h5a);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check(rd_q[`ST_NOISE], 1'b0);
    end
  endtask
  task t_mute;
    begin
      apb(1'b1, `OFS_CTRL1, 32'h08);
      node.send(9'h033, 8, -1);
      apb(1'b1, `OFS_CTRL2, 32'h0e);
      rd_chk(`OFS_CTRL2, 32'h0c);
      rd_chk(`OFS_DATA, 32'h33);
      apb(1'b1, `OFS_CTRL2, 32'h0e);
      rd_chk(`OFS_CTRL2, 32'h0e);
      node.send(9'h081, 8, -1);
      rd_chk(`OFS_CTRL2, 32'h0c);
      rd_chk(`OFS_DATA, 32'h81);
      apb(1'b1, `OFS_CTRL1, 32'h0);
      apb(1'b1, `OFS_CTRL2, 32'h0e);
      node.send(9'h0ff, 8, -1);
      repeat (400) @(posedge pclk);
      node.send(9'h042, 8, -1);
      rd_chk(`OFS_CTRL2, 32'h0c);
      rd_chk(`OFS_DATA, 32'h42);
    end
  endtask
  task t_break;
    reg hi;
    begin
      apb(1'b1, `OFS_CTRL2, 32'h0d);
      wait_frame(9'h000, 1'b0);
      apb(1'b1, `OFS_CTRL2, 32'h0c);
      k = 0;
      while (tx_pin !== 1'b1 && k < 400) begin
        @(posedge pclk);
        k = k + 1;
      end
      hi = 1'b1;
      for (k = 0; k < 15; k = k + 1) begin
        @(posedge pclk);
        if (tx_pin !== 1'b1) hi = 1'b0;
      end
      check(hi, 1'b1);
    end
  endtask
  task complete_run;
    begin
      if (fail_count == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    fail_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_tx;
    t_rx;
    t_mute;
    t_break;
    complete_run;
  end
  // a hang counts as a mismatch
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule // serial_comm_tb
bind serial_comm serial_comm_props props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_pin(tx_pin));
